// ---- verilog/four_bit_gpio_port.sv ----
// Four-pin general-purpose port with timer and bus clock alternate functions.
// Assumes a plain register port on clk and a timer on the same clock.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module four_bit_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  input  wire logic              clk,           // System bus clock, 250 MHz
  input  wire logic              reset_n,       // Asynchronous reset, active low
  input  wire logic              ce,            // Clock enable, freezes state
  input  wire logic [ADDR_W-1:0] addr,          // Register address
  input  wire logic [DATA_W-1:0] wrData,        // Write data
  input  wire logic              wrStb,         // Write strobe, one cycle
  input  wire logic              rdStb,         // Read strobe, one cycle
  output logic      [DATA_W-1:0] rdData,        // Read data, cycle after strobe
  input  wire logic [PINS-1:0]   pinIn,         // Pad input levels
  output logic      [PINS-1:0]   pinOut,        // Pad output levels
  output logic      [PINS-1:0]   pinOeN,        // Pad enables, low drives
  input  wire logic              busClock,      // Bus clock level to send out
  input  wire logic [1:0]        edgeLevelSel,  // Channel zero edge/level select
  input  wire logic              ch0Compare,    // Channel zero in compare mode
  input  wire logic              ch0CompareOut, // Channel zero compare level
  output logic                   ch0CaptureIn,  // Pin two level for capture
  input  wire logic [2:0]        prescaleSel,   // Timer prescaler select
  output logic                   timerExtClock  // Pin three level for timer
);

  // Elaboration check: the map needs pins zero to three and bit seven free
  if (PINS < NUM_PINS || PINS > BIT_CLK_OUT_EN) begin : g_bad_pins
    $error("PINS must be between four and seven");
  end

  // Elaboration check: the data bus must reach the clock enable bit
  if (DATA_W <= BIT_CLK_OUT_EN) begin : g_bad_width
    $error("DATA_W too narrow for the clock enable bit");
  end

  // Elaboration check: the two register offsets must differ
  if (ADDR_DIRECTION == ADDR_PIN_DATA) begin : g_bad_map
    $error("register offsets collide");
  end

  // Register state
  logic [PINS-1:0]   dataLatch_q;
  logic [PINS-1:0]   dirBits_q;
  logic              clkOutEn_q;
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdData_d;
  // Pin side
  logic [PINS-1:0]   pinLevel;
  logic [PINS-1:0]   altEn;
  logic [PINS-1:0]   altOe;
  logic [PINS-1:0]   altData;
  logic              ch0Active;
  logic              extClkActive;
  logic              wrData_hit;
  logic              wrDir_hit;

  assign wrData_hit = wrStb && (addr == ADDR_PIN_DATA);
  assign wrDir_hit  = wrStb && (addr == ADDR_DIRECTION);

  // Pin levels cross into clk before anyone reads them
  pin_sync #(
    .WIDTH  (PINS)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .async   (pinIn),
    .synced  (pinLevel)
  );

  // write lands whenever ce is high
  // No reset term on purpose: the latch keeps its value across reset.
  always_ff @(posedge clk) begin
    if (ce && wrData_hit) begin
      dataLatch_q <= wrData[PINS-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dirBits_q <= PINS'(DIR_RESET);
    end else if (ce && wrDir_hit) begin
      dirBits_q <= wrData[PINS-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkOutEn_q <= CLK_OUT_RESET;
    end else if (ce && wrDir_hit) begin
      clkOutEn_q <= wrData[BIT_CLK_OUT_EN];
    end
  end

  assign ch0Active = (edgeLevelSel != EDGE_LEVEL_OFF);
  assign extClkActive = (prescaleSel == PRESCALE_EXTCLK);

  // alternate override
  // Capture and external clock turn the pin into an input; compare drives it.
  always_comb begin
    altEn   = '0;
    altOe   = '0;
    altData = '0;
    altEn[PIN_BUS_CLK]   = clkOutEn_q;
    altOe[PIN_BUS_CLK]   = 1'b1;
    altData[PIN_BUS_CLK] = busClock;
    altEn[PIN_TIMER_CH0]   = ch0Active;
    altOe[PIN_TIMER_CH0]   = ch0Compare;
    altData[PIN_TIMER_CH0] = ch0CompareOut;
    altEn[PIN_TIMER_CLK]   = extClkActive;
  end

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    pin_cell u_cell (
      .latch   (dataLatch_q[i]),
      .dir     (dirBits_q[i]),
      .altEn   (altEn[i]),
      .altOe   (altOe[i]),
      .altData (altData[i]),
      .pinOut  (pinOut[i]),
      .pinOeN  (pinOeN[i])
    );
  end

  // Timer sees the synchronised pin levels; gated so idle pins read low
  assign ch0CaptureIn  = ch0Active && !ch0Compare && pinLevel[PIN_TIMER_CH0];
  assign timerExtClock = extClkActive && pinLevel[PIN_TIMER_CLK];

  // input write invisible
  // Readback mixes latch and pin per bit; unmapped addresses answer zero.
  always_comb begin
    rdData_d = READ_ZERO;
    if (addr == ADDR_PIN_DATA) begin
      rdData_d[PINS-1:0] = (dataLatch_q & dirBits_q) | (pinLevel & ~dirBits_q);
    end else if (addr == ADDR_DIRECTION) begin
      rdData_d[PINS-1:0]       = dirBits_q;
      rdData_d[BIT_CLK_OUT_EN] = clkOutEn_q;
    end
  end

  // Read data stand only in the cycle after the strobe, and are held longer while ce is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= READ_ZERO;
    end else if (ce) begin
      rdData_q <= rdStb ? rdData_d : READ_ZERO;
    end
  end
  assign rdData = rdData_q;

  // relies on software
  // A latch loaded before the direction flips needs no extra logic here:
  // the pin shows the latch from the same edge that sets the direction bit.

  // Helper state for the assertions
  logic              seenReset_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seenReset_q <= 1'b0;
    end else begin
      seenReset_q <= 1'b1;
    end
  end

  a_dir_reset: assert property (
    @(posedge clk) disable iff (!reset_n)
    !seenReset_q |-> (dirBits_q == PINS'(DIR_RESET) && !clkOutEn_q))
    else $error("direction bits not clear after reset");

  a_read_latch: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && rdStb && addr == ADDR_PIN_DATA && dirBits_q[1])
      |=> (rdData[1] == $past(dataLatch_q[1])))
    else $error("output pin read did not return latch");

  a_read_pin: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && rdStb && addr == ADDR_PIN_DATA && !dirBits_q[1])
      |=> (rdData[1] == $past(pinLevel[1])))
    else $error("input pin read did not return pin level");

  a_write_latch: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && wrData_hit) |=> (dataLatch_q == $past(wrData[PINS-1:0])))
    else $error("data write did not update latch");

  a_oe_dir: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!clkOutEn_q) |-> (pinOeN[1] == !dirBits_q[1]
      && pinOeN[PIN_BUS_CLK] == !dirBits_q[PIN_BUS_CLK]))
    else $error("pin enable does not follow direction");

  a_input_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && wrData_hit && !dirBits_q[1] && !wrDir_hit) |=> pinOeN[1])
    else $error("write to input pin started driving it");

  a_clk_out: assert property (
    @(posedge clk) disable iff (!reset_n)
    clkOutEn_q |-> (!pinOeN[PIN_BUS_CLK] && pinOut[PIN_BUS_CLK] == busClock))
    else $error("bus clock not on pin zero");

  a_clk_en_rw: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && wrDir_hit) |=> (clkOutEn_q == $past(wrData[BIT_CLK_OUT_EN])))
    else $error("bus clock enable did not take write");

  a_ch0_claim: assert property (
    @(posedge clk) disable iff (!reset_n)
    ch0Active |-> (pinOeN[PIN_TIMER_CH0] == !ch0Compare))
    else $error("timer channel did not own pin two");

  a_extclk_in: assert property (
    @(posedge clk) disable iff (!reset_n)
    extClkActive |-> (pinOeN[PIN_TIMER_CLK]
      && timerExtClock == pinLevel[PIN_TIMER_CLK]))
    else $error("pin three not an input for timer clock");

  a_unused_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && rdStb) |=> (rdData[BIT_CLK_OUT_EN-1:PINS] == '0))
    else $error("unimplemented bits read nonzero");

  a_override: assert property (
    @(posedge clk) disable iff (!reset_n)
    (extClkActive && dirBits_q[PIN_TIMER_CLK]) |-> pinOeN[PIN_TIMER_CLK])
    else $error("direction bit beat the timer clock claim");

  // Clock enable low must freeze direction, clock enable, read data and synchroniser output
  a_ce_freeze: assert property ( // Clock enable
    @(posedge clk) disable iff (!reset_n)
    !ce |=> ($stable(dirBits_q) && $stable(clkOutEn_q) && $stable(rdData_q)
      && $stable(pinLevel)))
    else $error("state moved while clock enable was low");

  // Direction and clock enable move only on a taken write
  a_dir_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !wrDir_hit) |=> ($stable(dirBits_q) && $stable(clkOutEn_q)))
    else $error("direction changed without a write");

  // Read data drop to zero unless a read was taken
  a_read_idle: assert property ( // Read timing
    @(posedge clk) disable iff (!reset_n)
    (ce && !rdStb) |=> (rdData == READ_ZERO))
    else $error("read data stood without a read");

  // Unmapped offsets answer zero
  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && rdStb && addr != ADDR_PIN_DATA && addr != ADDR_DIRECTION)
      |=> (rdData == READ_ZERO))
    else $error("unmapped address read nonzero");

  // Direction register reads back direction bits and clock enable
  a_dir_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && rdStb && addr == ADDR_DIRECTION)
      |=> (rdData[PINS-1:0] == $past(dirBits_q)
      && rdData[BIT_CLK_OUT_EN] == $past(clkOutEn_q)))
    else $error("direction readback wrong");

  // A free output pin shows its latch
  a_latch_out: assert property (
    @(posedge clk) disable iff (!reset_n)
    dirBits_q[1] |-> (!pinOeN[1] && pinOut[1] == dataLatch_q[1]))
    else $error("output pin does not show its latch");

  // Compare mode drives the compare level on pin two
  a_ch0_drive: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ch0Active && ch0Compare) |-> (pinOut[PIN_TIMER_CH0] == ch0CompareOut))
    else $error("compare level not on pin two");

  // Capture input stays low unless pin two is claimed for capture
  a_capture_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!ch0Active || ch0Compare) |-> !ch0CaptureIn)
    else $error("capture input active while not claimed");

  // Claimed for capture, pin two is an input feeding the timer
  a_capture_level: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ch0Active && !ch0Compare)
      |-> (pinOeN[PIN_TIMER_CH0] && ch0CaptureIn == pinLevel[PIN_TIMER_CH0]))
    else $error("capture path does not follow pin two");

  // Timer clock input stays low while pin three is free
  a_extclk_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    !extClkActive |-> !timerExtClock)
    else $error("timer clock active while pin three free");

  // readback of every pin against its direction bit
  for (genvar k = 0; k < PINS; k++) begin : g_rd_chk
    a_read_mix: assert property (
      @(posedge clk) disable iff (!reset_n)
      (ce && rdStb && addr == ADDR_PIN_DATA) |=> (rdData[k] == ($past(dirBits_q[k])
        ? $past(dataLatch_q[k]) : $past(pinLevel[k]))))
      else $error("pin readback ignores direction bit");
  end

  c_clk_out: cover property (
    @(posedge clk) disable iff (!reset_n) ce && wrDir_hit ##1 clkOutEn_q);
  c_read_input: cover property (
    @(posedge clk) disable iff (!reset_n)
    rdStb && addr == ADDR_PIN_DATA && dirBits_q != '1);
  c_compare: cover property (
    @(posedge clk) disable iff (!reset_n) ch0Active && ch0Compare);
  c_ext_clock: cover property (
    @(posedge clk) disable iff (!reset_n) extClkActive && timerExtClock);
  c_ce_hold: cover property (
    @(posedge clk) disable iff (!reset_n) !ce && wrStb);
endmodule
`default_nettype wire

// ---- inc/gpio_port_pkg.sv ----
// Constants shared by the four-pin port, its synchroniser and the bench.
// Assumes the register port carries the printed byte offsets unchanged.
package gpio_port_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          NUM_PINS        = 4;
  // Register offsets
  localparam logic [7:0]  ADDR_PIN_DATA   = 8'h01;
  localparam logic [7:0]  ADDR_DIRECTION  = 8'h05;
  // Field positions in the direction register
  localparam int          BIT_CLK_OUT_EN  = 7;
  // Pin assignments of the alternate functions
  localparam int          PIN_BUS_CLK     = 0;
  localparam int          PIN_TIMER_CH0   = 2;
  localparam int          PIN_TIMER_CLK   = 3;
  // Reset values
  localparam logic [3:0]  DIR_RESET       = 4'h0;
  localparam logic        CLK_OUT_RESET   = 1'b0;
  localparam logic [7:0]  READ_ZERO       = 8'h00;
  // Edge/level code that leaves channel zero as general purpose
  localparam logic [1:0]  EDGE_LEVEL_OFF  = 2'h0;
  // Prescaler code that picks the external timer clock pin
  localparam logic [2:0]  PRESCALE_EXTCLK = 3'h7;
  // Synchroniser depth for pin levels
  localparam int          SYNC_STAGES     = 2;
endpackage

// ---- verilog/pin_sync.sv ----
// Two-stage synchroniser for the package pin levels.
// Assumes the pins are asynchronous to clk; only stage two is read.
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,     // System bus clock
  input  wire logic             reset_n, // Asynchronous reset, active low
  input  wire logic             ce,      // Clock enable, freezes state
  input  wire logic [WIDTH-1:0] async,   // Raw pin levels
  output logic      [WIDTH-1:0] synced   // Levels after two flops
);
  logic [WIDTH-1:0] meta_q;

  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      synced <= '0;
    end else if (ce) begin
      meta_q <= async;
      synced <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pin_cell.sv ----
// One pin's output path: general purpose latch or an alternate function.
// Assumes the owner resolves which function claims the pin.
`timescale 1ns/100ps
`default_nettype none
module pin_cell (
  input  wire logic latch,   // Data latch bit
  input  wire logic dir,     // Direction bit, one drives
  input  wire logic altEn,   // Alternate function claims the pin
  input  wire logic altOe,   // Alternate function drives the pin
  input  wire logic altData, // Alternate function output value
  output logic      pinOut,  // Level offered to the pad
  output logic      pinOeN   // Output enable, low while driving
);
  // Claimed pins ignore latch and direction
  always_comb begin
    if (altEn) begin
      pinOut = altData;
      pinOeN = ~altOe;
    end else begin
      pinOut = latch;
      pinOeN = ~dir;
    end
  end
endmodule
`default_nettype wire

// ---- dv/pad_model.sv ----
// Pad model: resolves each package pin from the port and an outside driver.
// Assumes the outside driver lets go of a pin whenever the port drives it.
`timescale 1ns/100ps
`default_nettype none
module pad_model (
  input  wire logic [3:0] pinOut,   // Port output levels
  input  wire logic [3:0] pinOeN,   // Port enables, low drives
  input  wire logic [3:0] extLevel, // Outside driver levels
  output logic      [3:0] pinIn     // Resolved pad levels
);
  // hand-over rule: outside driver yields to the port, so no contention on the wire
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pinIn[i] = pinOeN[i] ? extLevel[i] : pinOut[i]; // Released pin takes outside level
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the four-pin port: register tasks and pin checks.
// Assumes pad_model resolves the pins and the bench plays the timer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import gpio_port_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rdData;
  logic       wrStb = 1'b0, rdStb = 1'b0, busClock = 1'b0, ce = 1'b1;
  logic [3:0] pinIn, pinOut, pinOeN, extLevel = 4'h5;
  logic [1:0] edgeLevelSel = 2'h0;
  logic [2:0] prescaleSel = 3'h0;
  logic       ch0Compare = 1'b0, ch0CompareOut = 1'b0, ch0CaptureIn, timerExtClock;
  int         num_errors = 0, tests_run = 0;

  always #2 clk = ~clk;
  // Free-running bus clock so the pin-zero path is seen to toggle
  always @(posedge clk) busClock <= ~busClock;

  four_bit_gpio_port four_bit_gpio_port_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .busClock(busClock),
    .edgeLevelSel(edgeLevelSel), .ch0Compare(ch0Compare), .ch0CompareOut(ch0CompareOut),
    .ch0CaptureIn(ch0CaptureIn), .prescaleSel(prescaleSel), .timerExtClock(timerExtClock));
  pad_model pad_model_inst (.pinOut(pinOut), .pinOeN(pinOeN), .extLevel(extLevel),
    .pinIn(pinIn));

  task automatic close_out;
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
    #1;
  endtask

  // Read data must stand in the cycle after the strobe and drop to zero after it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk("rdData", exp, rdData);
    @(posedge clk);
    #1 chk("rdData idle", READ_ZERO, rdData);
  endtask

  task automatic pulse_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  initial begin
    pulse_reset();
    rd(ADDR_DIRECTION, 8'h00);
    chk("pinOeN reset", 8'h0F, pinOeN);
    rd(8'h02, READ_ZERO);
    wr(ADDR_PIN_DATA, 8'hFA);
    chk("pinOeN input", 8'h0F, pinOeN);
    repeat (3) @(posedge clk);
    rd(ADDR_PIN_DATA, 8'h05);
    wr(ADDR_DIRECTION, 8'h7F);
    chk("pinOeN output", 8'h00, pinOeN);
    chk("pinOut", 8'h0A, pinOut);
    rd(ADDR_DIRECTION, 8'h0F);
    rd(ADDR_PIN_DATA, 8'h0A);
    // Latch survives a reset; direction does not
    @(posedge clk);
    pulse_reset();
    rd(ADDR_DIRECTION, 8'h00);
    wr(ADDR_DIRECTION, 8'h0F);
    rd(ADDR_PIN_DATA, 8'h0A);
    // Clock enable low: strobes are ignored and the port holds its state
    @(posedge clk);
    ce <= 1'b0;
    wr(ADDR_PIN_DATA, 8'h05);
    wr(ADDR_DIRECTION, 8'h00);
    chk("ce frozen oe", 8'h00, pinOeN);
    @(posedge clk);
    ce <= 1'b1;
    rd(ADDR_PIN_DATA, 8'h0A);
    // Bus clock takes pin zero although its latch bit is zero
    wr(ADDR_DIRECTION, 8'h80);
    rd(ADDR_DIRECTION, 8'h80);
    chk("clk pin oe", 8'h00, pinOeN[0]);
    chk("clk pin a", busClock, pinOut[0]);
    @(posedge clk);
    #1 chk("clk pin b", busClock, pinOut[0]);
    // Timer compare drives pin two while its direction bit is zero
    wr(ADDR_DIRECTION, 8'h00);
    @(posedge clk);
    edgeLevelSel  <= 2'h2;
    ch0Compare    <= 1'b1;
    ch0CompareOut <= 1'b1;
    @(posedge clk);
    #1 chk("ch0 oe", 8'h00, pinOeN[2]);
    chk("ch0 out", 8'h01, pinOut[2]);
    @(posedge clk);
    ch0Compare <= 1'b0;
    extLevel   <= 4'hC;
    repeat (4) @(posedge clk);
    #1 chk("ch0 cap oe", 8'h01, pinOeN[2]);
    chk("ch0 cap", 8'h01, ch0CaptureIn);
    @(posedge clk);
    edgeLevelSel <= EDGE_LEVEL_OFF;
    @(posedge clk);
    #1 chk("ch0 off", 8'h00, ch0CaptureIn);
    // External timer clock forces pin three to input over its direction bit
    wr(ADDR_PIN_DATA, 8'h00);
    wr(ADDR_DIRECTION, 8'h08);
    chk("pin3 out", 8'h00, pinOeN[3]);
    @(posedge clk);
    prescaleSel <= PRESCALE_EXTCLK;
    repeat (4) @(posedge clk);
    #1 chk("pin3 claim", 8'h01, pinOeN[3]);
    chk("ext clock", 8'h01, timerExtClock);
    @(posedge clk);
    prescaleSel <= 3'h0;
    @(posedge clk);
    #1 chk("pin3 free", 8'h00, pinOeN[3]);
    chk("ext clock off", 8'h00, timerExtClock);
    close_out();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
